/* core/idc_interrupt_dispatch.sv */
// Interrupt flag gathering, masking and vector dispatch toward the core.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module idc_interrupt_dispatch (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register port.
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    // Source events; one-cycle pulses except the external pin, whose rising edge is detected.
    input  wire logic        extIrqPin,
    input  wire logic        portChangeEvt,
    input  wire logic        baseCounterOvf,
    input  wire logic [10:0] periphEvt,
    // Core sequencer side.
    input  wire logic [12:0] pcCurrent,
    input  wire logic        returnFromIrqInstr,
    output logic             pcLoad,
    output logic      [12:0] pcVector,
    output logic             stackPush,
    output logic      [12:0] stackData,
    output logic             irqPending,
    // Interrupt output of the block's own event register.
    output logic             irqOut
);

    typedef enum logic [2:0] {
        IDC_IDLE   = 3'b001,
        IDC_SYNC   = 3'b010,
        IDC_VECTOR = 3'b100
    } idc_state_t;

    idc_state_t  state_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  pflagA_q;
    logic [2:0]  pflagB_q;
    logic [7:0]  penA_q;
    logic [2:0]  penB_q;
    logic [1:0]  qphase_q;
    logic        extPin_q;
    logic [1:0]  evtStat_q;
    logic [1:0]  evtEn_q;
    logic [7:0]  rdata_q;
    logic        pcLoad_q;
    logic [12:0] stackData_q;
    logic        cycleEnd;
    logic        extEdge;
    logic        coreReq;
    logic        periphReq;
    logic        request;
    logic        wrCtrl;
    logic        wrPflagA;
    logic        wrPflagB;
    logic        wrPenA;
    logic        wrPenB;
    logic        wrIrqClr;
    logic        wrIrqEn;
    logic        accept;
    logic [1:0]  evtSet;

    // Instruction cycle boundary; dispatch is only taken at a boundary so
    // instruction length never changes the wait.
    assign cycleEnd = (qphase_q == idc_pkg::QPHASE_LAST);
    assign extEdge  = extIrqPin & ~extPin_q;
    assign wrCtrl   = regWr && (regAddr == idc_pkg::ADDR_CTRL);
    // One decode per register keeps each write enable readable in the processes below.
    assign wrPflagA = regWr && (regAddr == idc_pkg::ADDR_PFLAG_A);
    assign wrPflagB = regWr && (regAddr == idc_pkg::ADDR_PFLAG_B);
    assign wrPenA   = regWr && (regAddr == idc_pkg::ADDR_PEN_A);
    assign wrPenB   = regWr && (regAddr == idc_pkg::ADDR_PEN_B);
    assign wrIrqClr = regWr && (regAddr == idc_pkg::ADDR_IRQ_CLR);
    assign wrIrqEn  = regWr && (regAddr == idc_pkg::ADDR_IRQ_EN);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            qphase_q <= 2'h0;
            extPin_q <= 1'b0;
        end else begin
            qphase_q <= qphase_q + 2'h1;
            extPin_q <= extIrqPin;
        end
    end

    assign coreReq = (ctrl_q[idc_pkg::CTRL_BASE_FLAG] & ctrl_q[idc_pkg::CTRL_BASE_EN])
                   | (ctrl_q[idc_pkg::CTRL_EXT_FLAG]  & ctrl_q[idc_pkg::CTRL_EXT_EN])
                   | (ctrl_q[idc_pkg::CTRL_CHG_FLAG]  & ctrl_q[idc_pkg::CTRL_CHG_EN]);
    assign periphReq = ctrl_q[idc_pkg::CTRL_GROUP_EN_BIT]
                     & (|(pflagA_q & penA_q) | |(pflagB_q & penB_q));
    assign request = ctrl_q[idc_pkg::CTRL_GLOBAL_EN_BIT] & (coreReq | periphReq);
    assign irqPending = request;
    assign accept = (state_q == IDC_VECTOR) && cycleEnd;

    // One instruction cycle to register the request, one to vector, giving
    // three or four cycles from an asynchronous event depending on phase.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= IDC_IDLE;
        end else begin
            unique case (state_q)
                IDC_IDLE: begin
                    if (request && cycleEnd) begin
                        state_q <= IDC_SYNC;
                    end
                end
                IDC_SYNC: begin
                    if (cycleEnd) begin
                        state_q <= request ? IDC_VECTOR : IDC_IDLE;
                    end
                end
                IDC_VECTOR: begin
                    if (cycleEnd) begin
                        state_q <= IDC_IDLE;
                    end
                end
                default: state_q <= IDC_IDLE;
            endcase
        end
    end

    // Control register holds global enable, group enable and core flags.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= idc_pkg::CTRL_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= regWdata;
            end
            if (accept) begin
                ctrl_q[idc_pkg::CTRL_GLOBAL_EN_BIT] <= 1'b0;
            end else if (returnFromIrqInstr) begin
                ctrl_q[idc_pkg::CTRL_GLOBAL_EN_BIT] <= 1'b1;
            end
            // Events win over a software clear in the same cycle.
            if (baseCounterOvf) begin
                ctrl_q[idc_pkg::CTRL_BASE_FLAG] <= 1'b1;
            end
            if (extEdge) begin
                ctrl_q[idc_pkg::CTRL_EXT_FLAG] <= 1'b1;
            end
            if (portChangeEvt) begin
                ctrl_q[idc_pkg::CTRL_CHG_FLAG] <= 1'b1;
            end
        end
    end

    // Peripheral flag and enable registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pflagA_q <= idc_pkg::PREG_RESET;
            pflagB_q <= idc_pkg::PREG_RESET[2:0];
            penA_q   <= idc_pkg::PREG_RESET;
            penB_q   <= idc_pkg::PREG_RESET[2:0];
        end else begin
            if (wrPenA) begin
                penA_q <= regWdata;
            end
            if (wrPenB) begin
                penB_q <= regWdata[2:0];
            end
            pflagA_q <= (wrPflagA ? regWdata : pflagA_q)
                        | periphEvt[7:0];
            pflagB_q <= (wrPflagB ? regWdata[2:0] : pflagB_q)
                        | periphEvt[10:8];
        end
    end

    // Dispatch outputs toward the program counter and stack.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pcLoad_q    <= 1'b0;
            stackData_q <= 13'h0000;
        end else begin
            pcLoad_q <= accept;
            if (accept) begin
                stackData_q <= pcCurrent;
            end
        end
    end

    assign pcLoad    = pcLoad_q;
    assign stackPush = pcLoad_q;
    assign stackData = stackData_q;
    assign pcVector  = idc_pkg::IRQ_VECTOR;

    // Block event status: dispatch taken and return executed.
    assign evtSet = {returnFromIrqInstr, accept};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evtStat_q <= 2'h0;
            evtEn_q   <= 2'h0;
        end else begin
            if (wrIrqEn) begin
                evtEn_q <= regWdata[1:0];
            end
            if (wrIrqClr) begin
                evtStat_q <= (evtStat_q & ~regWdata[1:0]) | evtSet;
            end else begin
                evtStat_q <= evtStat_q | evtSet;
            end
        end
    end

    assign irqOut = |(evtStat_q & evtEn_q);

    // Read data appear in the cycle after the read strobe only.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                idc_pkg::ADDR_CTRL:     rdata_q <= ctrl_q;
                idc_pkg::ADDR_PFLAG_A:  rdata_q <= pflagA_q;
                idc_pkg::ADDR_PFLAG_B:  rdata_q <= {5'h00, pflagB_q};
                idc_pkg::ADDR_PEN_A:    rdata_q <= penA_q;
                idc_pkg::ADDR_PEN_B:    rdata_q <= {5'h00, penB_q};
                idc_pkg::ADDR_IRQ_STAT: rdata_q <= {6'h00, evtStat_q};
                idc_pkg::ADDR_IRQ_EN:   rdata_q <= {6'h00, evtEn_q};
                default:                rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign regRdata = rdata_q;

    // Checks on the dispatch path, flag capture and the event status.
    // They sit beside the logic so a broken edit fails close to its cause.
    AST_RESET_GLOBAL_CLEAR: assert property (@(posedge clk) $rose(resetn) |-> !ctrl_q[7])
        else $error("Global enable set right after reset.");

    AST_ACCEPT_CLEARS_GLOBAL: assert property (@(posedge clk) disable iff (!resetn)
        accept && !wrCtrl |=> !ctrl_q[7] && pcLoad && stackPush)
        else $error("Acceptance did not clear enable or load PC.");

    AST_RETURN_SETS_GLOBAL: assert property (@(posedge clk) disable iff (!resetn)
        returnFromIrqInstr && !accept |=> ctrl_q[7])
        else $error("Return did not restore global enable.");

    AST_NO_REQ_WITHOUT_GLOBAL: assert property (@(posedge clk) disable iff (!resetn)
        !ctrl_q[7] |-> !irqPending)
        else $error("Request raised with global enable clear.");

    AST_EXT_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn)
        extIrqPin && !extPin_q |=> ctrl_q[1])
        else $error("External flag not set on pin edge.");

    AST_PERIPH_GATE: assert property (@(posedge clk) disable iff (!resetn)
        !ctrl_q[6] && !coreReq |-> !irqPending)
        else $error("Peripheral request passed without group enable.");

    AST_PERIPH_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn)
        periphEvt[0] |=> pflagA_q[0])
        else $error("Peripheral flag not set by event.");

    AST_LATENCY_BOUND: assert property (@(posedge clk) disable iff (!resetn)
        state_q == IDC_IDLE && request && cycleEnd && !returnFromIrqInstr && !regWr
        |-> ##[1:8] (state_q == IDC_VECTOR))
        else $error("Vector not reached within latency bound.");

    AST_VECTOR_ADDR: assert property (@(posedge clk) disable iff (!resetn)
        pcLoad |-> pcVector == 13'h0004)
        else $error("Vector address wrong.");

    AST_PCLOAD_PULSE: assert property (@(posedge clk) disable iff (!resetn)
        pcLoad |=> !pcLoad)
        else $error("Program counter load lasted more than one cycle.");

    AST_STACK_ADDR: assert property (@(posedge clk) disable iff (!resetn)
        accept |=> stackData == $past(pcCurrent))
        else $error("Pushed return address differs from the current address.");

    AST_GLOBAL_LOW_AT_LOAD: assert property (@(posedge clk) disable iff (!resetn)
        pcLoad |-> !ctrl_q[idc_pkg::CTRL_GLOBAL_EN_BIT])
        else $error("Global enable still set while the vector is loaded.");

    AST_BASE_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn)
        baseCounterOvf |=> ctrl_q[idc_pkg::CTRL_BASE_FLAG])
        else $error("Base counter flag not set by overflow.");

    AST_CHG_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn)
        portChangeEvt |=> ctrl_q[idc_pkg::CTRL_CHG_FLAG])
        else $error("Port change flag not set by event.");

    AST_PERIPH_B_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn)
        periphEvt[8] |=> pflagB_q[0])
        else $error("Second peripheral flag register not set by event.");

    AST_FLAG_IGNORES_MASK: assert property (@(posedge clk) disable iff (!resetn)
        periphEvt[7] && !penA_q[7] && !ctrl_q[idc_pkg::CTRL_GLOBAL_EN_BIT] |=> pflagA_q[7])
        else $error("Masked peripheral event did not set its flag.");

    AST_LOAD_ON_BOUNDARY: assert property (@(posedge clk) disable iff (!resetn)
        pcLoad |-> $past(cycleEnd))
        else $error("Vector taken away from an instruction boundary.");

    AST_CORE_MASK: assert property (@(posedge clk) disable iff (!resetn)
        !ctrl_q[5] && !ctrl_q[4] && !ctrl_q[3] && !ctrl_q[6] |-> !irqPending)
        else $error("Request raised with every source enable clear.");

    AST_IDLE_WITHOUT_REQ: assert property (@(posedge clk) disable iff (!resetn)
        state_q == IDC_IDLE && !request |=> state_q == IDC_IDLE)
        else $error("Dispatch started without a request.");

    AST_REQ_DROPS_SYNC: assert property (@(posedge clk) disable iff (!resetn)
        state_q == IDC_SYNC && cycleEnd && !request |=> state_q == IDC_IDLE)
        else $error("Dispatch went on after the request vanished.");

    AST_DISPATCH_STATUS: assert property (@(posedge clk) disable iff (!resetn)
        accept |=> evtStat_q[idc_pkg::ST_DISPATCH])
        else $error("Dispatch status bit not set on acceptance.");

    AST_RETURN_STATUS: assert property (@(posedge clk) disable iff (!resetn)
        returnFromIrqInstr |=> evtStat_q[idc_pkg::ST_RETURN])
        else $error("Return status bit not set by the return instruction.");

    AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        evtStat_q[0] && !(wrIrqClr && regWdata[0]) |=> evtStat_q[0])
        else $error("Dispatch status bit dropped without a clear.");

endmodule : idc_interrupt_dispatch

/* core/idc_pkg.sv */
// Package of constants shared by the interrupt dispatch control block.
package idc_pkg;
    // Register port addresses.
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_PFLAG_A   = 4'h1;
    localparam logic [3:0] ADDR_PFLAG_B   = 4'h2;
    localparam logic [3:0] ADDR_PEN_A     = 4'h3;
    localparam logic [3:0] ADDR_PEN_B     = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_CLR   = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN    = 4'h7;
    // Control register field positions.
    localparam int CTRL_GLOBAL_EN_BIT = 7;
    localparam int CTRL_GROUP_EN_BIT  = 6;
    localparam int CTRL_BASE_EN    = 5;
    localparam int CTRL_EXT_EN     = 4;
    localparam int CTRL_CHG_EN     = 3;
    localparam int CTRL_BASE_FLAG  = 2;
    localparam int CTRL_EXT_FLAG   = 1;
    localparam int CTRL_CHG_FLAG   = 0;
    // Reset values.
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] PREG_RESET  = 8'h00;
    // Number of sources: three core ones plus eleven peripheral ones.
    localparam int NUM_SOURCES     = 14;
    localparam int PFLAG_B_WIDTH   = 3;
    // Instruction cycle is four core clocks.
    localparam logic [1:0] QPHASE_LAST = 2'h3;
    // Vector and address widths.
    localparam int PC_WIDTH        = 13;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // Status bit positions of the interrupt output register.
    localparam int ST_DISPATCH = 0;
    localparam int ST_RETURN   = 1;
    localparam int ST_WIDTH    = 2;
endpackage : idc_pkg

/* testbench/idc_core_model.sv */
// Behavioural model of the core sequencer that faces the dispatch block.
`timescale 1ns/1ps
module idc_core_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Dispatch side.
    input  wire logic        pcLoad,
    input  wire logic [12:0] pcVector,
    input  wire logic        stackPush,
    input  wire logic [12:0] stackData,
    output logic      [12:0] pcCurrent,
    output logic             returnFromIrqInstr,
    // Bench command that runs the return instruction.
    input  wire logic        doReturn
);
    logic [12:0] stackTop_q;

    // The program counter stays put outside jumps so the saved address is predictable.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pcCurrent <= 13'h0123;
        end else if (pcLoad) begin
            pcCurrent <= pcVector;
        end else if (returnFromIrqInstr) begin
            pcCurrent <= stackTop_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stackTop_q <= 13'h0000;
        end else if (stackPush) begin
            stackTop_q <= stackData;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            returnFromIrqInstr <= 1'b0;
        end else begin
            returnFromIrqInstr <= doReturn;
        end
    end
endmodule : idc_core_model

/* testbench/tb_interrupt_dispatch_control.sv */
// Self-checking testbench of the interrupt dispatch block with a core model.
`timescale 1ns/1ps
module tb_interrupt_dispatch_control;
    logic        clk, resetn, regWr, regRd, extIrqPin, portChangeEvt, baseCounterOvf;
    logic        returnFromIrqInstr, pcLoad, stackPush, irqPending, irqOut, doReturn;
    logic [3:0]  regAddr;
    logic [7:0]  regWdata, regRdata, rv;
    logic [10:0] periphEvt;
    logic [12:0] pcCurrent, pcVector, stackData;
    int          errTotal, nTests, cnt;

    idc_interrupt_dispatch dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extIrqPin(extIrqPin),
        .portChangeEvt(portChangeEvt), .baseCounterOvf(baseCounterOvf), .periphEvt(periphEvt),
        .pcCurrent(pcCurrent), .returnFromIrqInstr(returnFromIrqInstr), .pcLoad(pcLoad),
        .pcVector(pcVector), .stackPush(stackPush), .stackData(stackData),
        .irqPending(irqPending), .irqOut(irqOut));
    idc_core_model core (.clk(clk), .resetn(resetn), .pcLoad(pcLoad), .pcVector(pcVector),
        .stackPush(stackPush), .stackData(stackData), .pcCurrent(pcCurrent),
        .returnFromIrqInstr(returnFromIrqInstr), .doReturn(doReturn));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    task automatic ev(input logic [2:0] c, input logic [10:0] p);
        @(posedge clk);
        portChangeEvt <= c[0]; extIrqPin <= c[1]; baseCounterOvf <= c[2]; periphEvt <= p;
        @(posedge clk);
        portChangeEvt <= 1'b0; extIrqPin <= 1'b0; baseCounterOvf <= 1'b0; periphEvt <= 11'h000;
        #1;
    endtask : ev

    // Bounded wait; the caller judges the count, so a hang shows as a mismatch.
    task automatic wait_load(output int n);
        n = 0;
        while (pcLoad !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_load

    task automatic ret();
        @(posedge clk);
        doReturn <= 1'b1;
        @(posedge clk);
        doReturn <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : ret

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        #(8 * 20000);
        errTotal++;
        tally_and_finish();
    end

    initial begin
        {resetn, regWr, regRd, extIrqPin, portChangeEvt, baseCounterOvf, doReturn} = 7'h00;
        regAddr = 4'h0; regWdata = 8'h00; periphEvt = 11'h000; errTotal = 0; nTests = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rd(idc_pkg::ADDR_CTRL, rv); chk("ctrl reset", rv, 8'h00);
        chk("pending idle", irqPending, 1'b0);
        $display("Test reset done");
        ev(3'h7, 11'h7ff);
        rd(idc_pkg::ADDR_CTRL, rv); chk("core flags", rv, 8'h07);
        rd(idc_pkg::ADDR_PFLAG_A, rv); chk("flags a", rv, 8'hff);
        rd(idc_pkg::ADDR_PFLAG_B, rv); chk("flags b", rv, 8'h07);
        wr(idc_pkg::ADDR_CTRL, 8'hc7);
        chk("masked", irqPending, 1'b0);
        wr(idc_pkg::ADDR_CTRL, 8'h07);
        wr(idc_pkg::ADDR_PEN_A, 8'hff);
        wr(idc_pkg::ADDR_PEN_B, 8'h07);
        wr(idc_pkg::ADDR_CTRL, 8'h7f);
        chk("global off", irqPending, 1'b0);
        wr(idc_pkg::ADDR_PFLAG_A, 8'h00);
        wr(idc_pkg::ADDR_PFLAG_B, 8'h00);
        wr(idc_pkg::ADDR_CTRL, 8'h00);
        $display("Test flags done");
        wr(idc_pkg::ADDR_IRQ_EN, 8'h03);
        ev(3'h0, 11'h001);
        wr(idc_pkg::ADDR_CTRL, 8'h80);
        chk("group off", irqPending, 1'b0);
        wr(idc_pkg::ADDR_CTRL, 8'hc0);
        chk("pending", irqPending, 1'b1);
        wait_load(cnt);
        chk("accept time", 16'(cnt <= 12), 16'h0001);
        chk("vector", pcVector, 13'h0004);
        chk("push", stackPush, 1'b1);
        chk("return addr", stackData, 13'h0123);
        rd(idc_pkg::ADDR_CTRL, rv); chk("global cleared", rv, 8'h40);
        rd(idc_pkg::ADDR_IRQ_STAT, rv); chk("status take", rv, 8'h01);
        chk("irq out", irqOut, 1'b1);
        wr(idc_pkg::ADDR_PFLAG_A, 8'h00);
        ret();
        rd(idc_pkg::ADDR_CTRL, rv); chk("global again", rv, 8'hc0);
        chk("no retrigger", irqPending, 1'b0);
        wr(idc_pkg::ADDR_IRQ_STAT, 8'hff);
        rd(idc_pkg::ADDR_IRQ_STAT, rv); chk("status ro", rv, 8'h03);
        wr(idc_pkg::ADDR_IRQ_CLR, 8'h03);
        chk("irq cleared", irqOut, 1'b0);
        rd(4'h8, rv); chk("unmapped", rv, 8'h00);
        $display("Test dispatch done");
        // Passes 1 to 3 start the pin edge at three phases of the instruction cycle; pass 0 repeats the phase of pass 2.
        for (int i = 0; i < 4; i++) begin
            wr(idc_pkg::ADDR_CTRL, 8'h90);
            repeat (i) @(posedge clk);
            @(posedge clk);
            extIrqPin <= 1'b1;
            wait_load(cnt);
            chk("latency", 16'(cnt >= 9 && cnt <= 16), 16'h0001);
            chk("saved pc", stackData, 13'h0123);
            extIrqPin <= 1'b0;
            wr(idc_pkg::ADDR_CTRL, 8'h10);
            ret();
        end
        $display("Test latency done");
        tally_and_finish();
    end
endmodule : tb_interrupt_dispatch_control
